//--- logic/spw_fb_div.sv
// Feedback divider built from A, B and C counters around a 16/17/20/21 prescaler
`timescale 1ns/1ns
`default_nettype none
module spw_fb_div (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        enable,
  input  wire logic        vcoTick,
  input  wire logic [10:0] nDiv,
  output var  logic        fbPulse
);

  logic [6:0] cIdx;
  logic [4:0] pCnt;
  logic [6:0] cVal;
  logic [1:0] bVal;
  logic [1:0] aVal;
  logic [4:0] modulus;
  logic       presEnd;
  logic       cycEnd;

  // ------------------------------------------------------------
  // Counter split and prescaler modulus
  // ------------------------------------------------------------
  assign cVal    = nDiv[10:4];                                   // R7
  assign bVal    = nDiv[3:2];                                    // R7
  assign aVal    = nDiv[1:0];                                    // R7
  assign modulus = spw_pkg::PRESC_BASE
                 + ((cIdx < {5'h00, bVal}) ? 5'h04 : 5'h00)
                 + ((cIdx < {5'h00, aVal}) ? 5'h01 : 5'h00);     // R7
  assign presEnd = (pCnt == modulus - 5'h01);
  assign cycEnd  = presEnd && (cIdx == cVal - 7'h01);

  // Count input ticks through C prescaler cycles
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pCnt    <= 5'h00;
      cIdx    <= 7'h00;
      fbPulse <= 1'b0;
    end else begin
      fbPulse <= 1'b0;
      if (!enable) begin
        pCnt <= 5'h00;
        cIdx <= 7'h00;
      end else if (vcoTick) begin
        pCnt <= presEnd ? 5'h00 : pCnt + 5'h01;
        if (cycEnd) begin
          cIdx    <= 7'h00;
          fbPulse <= 1'b1;                                       // R7
        end else if (presEnd) begin
          cIdx <= cIdx + 7'h01;
        end
      end
    end
  end

endmodule // spw_fb_div
`default_nettype wire

//--- logic/spw_pkg.sv
// Shared constants and types of the synthesizer programming word map
package spw_pkg;

  // ------------------------------------------------------------
  // Bus register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] PROG_OFS = 8'h00;  // Programming word entry
  localparam logic [7:0] CTRL_OFS = 8'h04;  // Block control
  localparam logic [7:0] STAT_OFS = 8'h08;  // Block status
  localparam logic [7:0] NDIV_OFS = 8'h0c;  // Assembled feedback divider
  localparam logic [7:0] NUM_OFS  = 8'h10;  // Effective numerator
  localparam logic [7:0] DEN_OFS  = 8'h14;  // Effective denominator
  localparam logic [7:0] BANK_OFS = 8'h40;  // Word readback, 4 bytes per code

  // ------------------------------------------------------------
  // Word select codes
  // ------------------------------------------------------------
  localparam logic [3:0] CODE_W0  = 4'h0;
  localparam logic [3:0] CODE_W1  = 4'h1;
  localparam logic [3:0] CODE_W2  = 4'h2;
  localparam logic [3:0] CODE_W3  = 4'h3;
  localparam logic [3:0] CODE_W4  = 4'h4;
  localparam logic [3:0] CODE_W5  = 4'h5;
  localparam logic [3:0] CODE_W6  = 4'h6;
  localparam logic [3:0] CODE_W7  = 4'h7;
  localparam logic [3:0] CODE_W8  = 4'h8;
  localparam logic [3:0] CODE_W9  = 4'h9;
  localparam logic [3:0] CODE_W12 = 4'hc;

  // ------------------------------------------------------------
  // Field positions inside the 20-bit data payload
  // ------------------------------------------------------------
  localparam int W0_NLO_POS   = 12;  // Divider bits 7..0
  localparam int W0_NUMLO_POS = 0;   // Numerator bits 11..0
  localparam int W1_NUMHI_POS = 0;   // Numerator bits 21..12
  localparam int W1_NHI_POS   = 10;  // Divider bits 10..8
  localparam int W1_ICP_POS   = 13;  // Pump current
  localparam int W2_REF_POS   = 0;   // Reference divider
  localparam int W2_DENLO_POS = 6;   // Denominator bits 11..0
  localparam int W3_DENHI_POS = 0;   // Denominator bits 21..12
  localparam int W3_TPIN_POS  = 10;  // Test pin select
  localparam int W3_ORDER_POS = 14;  // Modulator order
  localparam int W3_DITH_POS  = 16;  // Dither
  localparam int W3_WIDE_POS  = 18;  // Wide fraction select
  localparam int W3_HALF_POS  = 19;  // Output halving
  localparam int W5_SRST_POS  = 14;  // Soft reset

  // ------------------------------------------------------------
  // Values after reset, limits and counts
  // ------------------------------------------------------------
  localparam logic [19:0] WORD_RST     = 20'h00000;
  localparam logic [31:0] CTRL_RST     = 32'h00000000;
  localparam logic [21:0] FRAC_NARROW  = 22'h000fff;  // 4095
  localparam logic [21:0] FRAC_WIDE    = 22'h3fffff;  // 4194303
  localparam logic [4:0]  PRESC_BASE   = 5'h10;       // Prescaler base 16
  localparam logic [11:0] CAL_CYCLES   = 12'h040;     // Calibration length

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN  = 2'b10
  } spw_cal_t;

  typedef struct packed {
    logic [10:0] nDiv;
    logic [21:0] numerator;
    logic [21:0] denominator;
    logic [5:0]  refDiv;
    logic [3:0]  pumpCurrent;
    logic [1:0]  order;
    logic [1:0]  dither;
    logic [3:0]  testPinSel;
    logic        wide_fraction_select;
    logic        halfOut;
    logic        softReset;
  } spw_fields_t;

endpackage

//--- logic/spw_word_map.sv
// Programming word map of the synthesizer behind an AHB-Lite slave
// Operation
// (R1) Every word-zero write starts VCO calibration; other words never do.
// (R2) Numerator joins low part from word zero and upper part from word one.
// (R3) Wide select clear: numerator 0..4095, word-one upper bits ignored.
// (R4) Wide select set: full 22-bit numerator, 0..4194303.
// (R5) Host keeps numerator restrictions when reference divider is 16 or 32.
// (R6) Feedback divider is 11 bits: 8 low from word zero, 3 high from word one.
// (R7) Divider realised by A, B, C counters with 16/17/20/21 prescaler.
// (R8) Host avoids divider below 48, 52..54, above 2039; 48..51 order one only.
// (R9) Word is 20 data bits plus 4-bit select code, routed by that code.
// (R10) Host writes words in the cold-start order.
// (R11) Host waits 10 ms after last word-five write before word one.
// (R12) Host writes words nine, twelve and constant bits as fixed patterns.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module spw_word_map (
  input  wire logic               ref_clk,
  input  wire logic               arst_n,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output var  logic [31:0]        hrdata,
  output logic                    hresp,
  input  wire logic               vcoTick,
  output var  spw_pkg::spw_fields_t fields,
  output var  logic               calStart,
  output logic                    calBusy,
  output logic                    fbPulse
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [19:0]       bank [0:15];
  logic [23:0]       lastWord;
  logic              fbEnable;
  logic              badCode;
  logic [7:0]        calCount;
  logic [11:0]       calTimer;
  spw_pkg::spw_cal_t calState;
  spw_pkg::spw_cal_t next_calState;
  logic              dpWrite;
  logic              dpRead;
  logic [7:0]        dpAddr;
  logic              readPend;
  logic              accept;
  logic              progWrite;
  logic              ctrlWrite;
  logic [23:0]       progWord;
  logic [3:0]        progCode;
  logic              codeOk;
  logic              startCal;
  logic [10:0]       nDivAsm;
  logic [21:0]       numFull;
  logic [21:0]       numEff;
  logic [21:0]       denFull;
  logic [21:0]       denEff;
  logic              wideSel;
  logic [31:0]       readMux;
  logic [31:0]       statWord;
  logic [3:0]        bankIdx;
  logic              bankHit;
  spw_pkg::spw_fields_t next_fields;

  // ------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------

  // True for the eleven codes that select a stored word
  function automatic logic isWordCode(input logic [3:0] code);
    case (code)
      spw_pkg::CODE_W0, spw_pkg::CODE_W1, spw_pkg::CODE_W2,
      spw_pkg::CODE_W3, spw_pkg::CODE_W4, spw_pkg::CODE_W5,
      spw_pkg::CODE_W6, spw_pkg::CODE_W7, spw_pkg::CODE_W8,
      spw_pkg::CODE_W9, spw_pkg::CODE_W12: isWordCode = 1'b1;
      default:                             isWordCode = 1'b0;
    endcase
  endfunction

  // Select a narrow or wide fraction word
  function automatic logic [21:0] fracSel(input logic wide,
                                          input logic [21:0] full);
    fracSel = wide ? (full & spw_pkg::FRAC_WIDE)
                   : (full & spw_pkg::FRAC_NARROW);
  endfunction

  // ------------------------------------------------------------
  // Bus address phase decode
  // ------------------------------------------------------------
  assign accept    = hsel && hready && htrans[1];
  assign hreadyout = !readPend;      // Reads take one wait state
  assign hresp     = 1'b0;           // Always OKAY

  // Latch the address phase for the following data phase
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dpWrite <= 1'b0;
      dpRead  <= 1'b0;
      dpAddr  <= 8'h00;
    end else if (hready) begin
      dpWrite <= accept && hwrite;
      dpRead  <= accept && !hwrite;
      dpAddr  <= haddr[7:0];
    end
  end

  // Wait-state flag for read data phases
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      readPend <= 1'b0;
    end else begin
      readPend <= accept && !hwrite && !readPend;
    end
  end

  // ------------------------------------------------------------
  // Programming word entry
  // ------------------------------------------------------------
  assign progWrite = dpWrite && (dpAddr == spw_pkg::PROG_OFS);
  assign ctrlWrite = dpWrite && (dpAddr == spw_pkg::CTRL_OFS);
  assign progWord  = hwdata[23:0];
  assign progCode  = progWord[3:0];                              // R9
  assign codeOk    = isWordCode(progCode);                       // R9
  assign startCal  = progWrite && (progCode == spw_pkg::CODE_W0); // R1

  // Route the payload to the word named by the select code
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 16; i++) begin
        bank[i] <= spw_pkg::WORD_RST;
      end
      lastWord <= 24'h000000;
    end else if (progWrite) begin
      lastWord <= progWord;
      if (codeOk) begin
        bank[progCode] <= progWord[23:4];                        // R9
      end
    end
  end

  // Control register and sticky bad-code flag
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fbEnable <= spw_pkg::CTRL_RST[0];
      badCode  <= 1'b0;
    end else begin
      if (ctrlWrite) begin
        fbEnable <= hwdata[0];
      end
      if (progWrite && !codeOk) begin
        badCode <= 1'b1;               // Set wins over clear
      end else if (ctrlWrite && hwdata[1]) begin
        badCode <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Field assembly
  // ------------------------------------------------------------
  assign wideSel = bank[spw_pkg::CODE_W3][spw_pkg::W3_WIDE_POS];
  assign nDivAsm = {bank[spw_pkg::CODE_W1][spw_pkg::W1_NHI_POS +: 3],
                    bank[spw_pkg::CODE_W0][spw_pkg::W0_NLO_POS +: 8]}; // R6
  assign numFull = {bank[spw_pkg::CODE_W1][spw_pkg::W1_NUMHI_POS +: 10],
                    bank[spw_pkg::CODE_W0][spw_pkg::W0_NUMLO_POS +: 12]}; // R2
  assign numEff  = fracSel(wideSel, numFull);                    // R3 R4
  assign denFull = {bank[spw_pkg::CODE_W3][spw_pkg::W3_DENHI_POS +: 10],
                    bank[spw_pkg::CODE_W2][spw_pkg::W2_DENLO_POS +: 12]};
  assign denEff  = fracSel(wideSel, denFull);

  // Gather every decoded field
  always_comb begin
    next_fields             = '0;
    next_fields.nDiv        = nDivAsm;                           // R6
    next_fields.numerator   = numEff;                            // R3 R4
    next_fields.denominator = denEff;
    next_fields.refDiv      = bank[spw_pkg::CODE_W2][spw_pkg::W2_REF_POS +: 6];
    next_fields.pumpCurrent = bank[spw_pkg::CODE_W1][spw_pkg::W1_ICP_POS +: 4];
    next_fields.order       = bank[spw_pkg::CODE_W3][spw_pkg::W3_ORDER_POS +: 2];
    next_fields.dither      = bank[spw_pkg::CODE_W3][spw_pkg::W3_DITH_POS +: 2];
    next_fields.testPinSel  = bank[spw_pkg::CODE_W3][spw_pkg::W3_TPIN_POS +: 4];
    next_fields.wide_fraction_select = wideSel;
    next_fields.halfOut     = bank[spw_pkg::CODE_W3][spw_pkg::W3_HALF_POS];
    next_fields.softReset   = bank[spw_pkg::CODE_W5][spw_pkg::W5_SRST_POS];
  end

  // Registered field outputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fields <= '0;
    end else begin
      fields <= next_fields;
    end
  end

  // ------------------------------------------------------------
  // VCO frequency calibration sequencer
  // ------------------------------------------------------------
  assign calBusy = (calState == spw_pkg::CAL_RUN);

  // Next state: any word-zero write (re)launches a run
  always_comb begin
    case (calState)
      spw_pkg::CAL_IDLE:
        next_calState = startCal ? spw_pkg::CAL_RUN : spw_pkg::CAL_IDLE; // R1
      spw_pkg::CAL_RUN:
        next_calState = (calTimer == 12'h001 && !startCal)
                      ? spw_pkg::CAL_IDLE : spw_pkg::CAL_RUN;
      default:
        next_calState = spw_pkg::CAL_IDLE;
    endcase
  end

  // State, run timer, start pulse and run counter
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      calState <= spw_pkg::CAL_IDLE;
      calTimer <= 12'h000;
      calStart <= 1'b0;
      calCount <= 8'h00;
    end else begin
      calState <= next_calState;
      calStart <= startCal;                                      // R1
      if (startCal) begin
        calTimer <= spw_pkg::CAL_CYCLES;                         // R1
        calCount <= calCount + 8'h01;
      end else if (calTimer != 12'h000) begin
        calTimer <= calTimer - 12'h001;
      end
    end
  end

  // ------------------------------------------------------------
  // Feedback divider
  // ------------------------------------------------------------
  spw_fb_div u_fbDiv (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .enable  (fbEnable),
    .vcoTick (vcoTick),
    .nDiv    (fields.nDiv),
    .fbPulse (fbPulse)
  );

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  assign statWord = {16'h0000, calCount, 6'h00, badCode, calBusy};
  assign bankHit  = (dpAddr[7:6] == spw_pkg::BANK_OFS[7:6]);
  assign bankIdx  = dpAddr[5:2];

  // Select the word for the pending read
  always_comb begin
    readMux = 32'h00000000;
    if (bankHit) begin
      readMux = isWordCode(bankIdx) ? {8'h00, bank[bankIdx], bankIdx}
                                    : 32'h00000000;
    end else begin
      case (dpAddr)
        spw_pkg::PROG_OFS: readMux = {8'h00, lastWord};
        spw_pkg::CTRL_OFS: readMux = {31'h00000000, fbEnable};
        spw_pkg::STAT_OFS: readMux = statWord;
        spw_pkg::NDIV_OFS: readMux = {21'h000000, fields.nDiv};
        spw_pkg::NUM_OFS:  readMux = {10'h000, fields.numerator};
        spw_pkg::DEN_OFS:  readMux = {10'h000, fields.denominator};
        default:           readMux = 32'h00000000;
      endcase
    end
  end

  // Read data registered in the wait cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h00000000;
    end else if (readPend) begin
      hrdata <= readMux;
    end
  end

endmodule // spw_word_map
`default_nettype wire

//--- verification/spw_host_model.sv
// Host controller model that writes programming words over AHB-Lite
`timescale 1ns/1ns
`default_nettype none
module spw_host_model #(
  parameter int SETTLE_CYCLES = 50  // Shortened regulator settle wait
) (
  input  wire logic        ref_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata
);
  // Idle bus at time zero
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h00000000;
  end

  // Wait for a rising edge at which hready is high
  task automatic wait_ready();
    @(negedge ref_clk);
    while (hready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
  endtask

  // Single word transfer, address phase held until accepted
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h000000, a};
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  // One 24-bit word: payload above, select code in the low four bits
  task automatic put_word(input logic [23:0] w);
    logic [31:0] unused;
    xfer(1'b1, spw_pkg::PROG_OFS, {8'h00, w}, unused);
  endtask

  // Regulator settle wait between the last word five and word one
  task automatic settle();
    repeat (SETTLE_CYCLES) @(posedge ref_clk);
  endtask
endmodule // spw_host_model
`default_nettype wire

//--- verification/spw_word_map_checker.sv
// Concurrent checks on the ports of the programming word map
`timescale 1ns/1ns
`default_nettype none
module spw_word_map_checker (
  input  wire logic                 ref_clk,
  input  wire logic                 arst_n,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  input  wire logic                 hreadyout,
  input  wire logic                 hresp,
  input  wire spw_pkg::spw_fields_t fields,
  input  wire logic                 calStart,
  input  wire logic                 calBusy,
  input  wire logic                 fbPulse
);
  // ------------------------------------------------------------
  // Data phase tracking
  // ------------------------------------------------------------
  logic       apWr;
  logic [7:0] apAddr;
  wire        take   = hsel && hready && htrans[1];
  wire        progWr = apWr && hready && (apAddr == spw_pkg::PROG_OFS);
  wire  [3:0] code   = hwdata[3:0];

  // Remember a write address phase until its data phase completes
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      apWr   <= 1'b0;
      apAddr <= 8'h00;
    end else if (hready) begin
      apWr   <= take && hwrite;
      apAddr <= haddr[7:0];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_cal_after_zero: assert property (progWr && code == 4'h0 |=> calStart)
    else $error("word zero write gave no calibration start");
  a_no_cal_other: assert property (apWr && hready && !(progWr && code == 4'h0) |=> !calStart)
    else $error("calibration started without a word zero write");
  a_cal_busy_set: assert property (calStart |-> calBusy)
    else $error("calibration start without busy");
  // Fields are registered behind the stored word, so they follow two edges later
  a_ndiv_low: assert property (progWr && code == 4'h0 |=> ##1
    fields.nDiv[7:0] == $past(hwdata[23:16], 2))
    else $error("divider low bits not taken from word zero");
  a_num_low: assert property (progWr && code == 4'h0 |=> ##1
    fields.numerator[11:0] == $past(hwdata[15:4], 2))
    else $error("numerator low part not taken from word zero");
  a_ndiv_high: assert property (progWr && code == 4'h1 |=> ##1
    fields.nDiv[10:8] == $past(hwdata[16:14], 2))
    else $error("divider high bits not taken from word one");
  a_wide_select: assert property (progWr && code == 4'h3 |=> ##1
    fields.wide_fraction_select == $past(hwdata[22], 2))
    else $error("wide select not taken from word three");
  a_narrow_mask: assert property (!fields.wide_fraction_select |-> fields.numerator[21:12] == 10'h000)
    else $error("numerator upper bits used while narrow");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_fb_single: assert property (fbPulse |=> !fbPulse)
    else $error("feedback pulse longer than one cycle");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");

  c_word_zero: cover property (progWr && code == 4'h0);
  c_read: cover property (take && !hwrite);
  c_fb_pulse: cover property (fbPulse);
endmodule // spw_word_map_checker

bind spw_word_map spw_word_map_checker u_spw_word_map_checker (
  .ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .fields(fields), .calStart(calStart), .calBusy(calBusy), .fbPulse(fbPulse)
);
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking testbench of the programming word map
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic                 ref_clk;
  logic                 arst_n;
  logic                 vcoTick;
  logic                 hsel;
  logic                 hwrite;
  logic [31:0]          haddr;
  logic [31:0]          hwdata;
  logic [31:0]          hrdata;
  logic [31:0]          rd;
  logic [1:0]           htrans;
  logic [2:0]           hsize;
  logic                 hreadyout;
  logic                 hresp;
  logic                 calStart;
  logic                 calBusy;
  logic                 fbPulse;
  spw_pkg::spw_fields_t fields;
  int                   fails;
  int                   n_checks;
  int                   n;

  spw_word_map u_spw_word_map (
    .ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .vcoTick(vcoTick),
    .fields(fields), .calStart(calStart), .calBusy(calBusy), .fbPulse(fbPulse)
  );

  spw_host_model u_spw_host_model (
    .ref_clk(ref_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_spw_host_model.xfer(1'b1, a, d, rd);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    u_spw_host_model.xfer(1'b0, a, 32'h00000000, rd);
    chk(rd, exp);
  endtask

  // Write a word, then look at the cycle after its commit edge
  task automatic put(input logic [23:0] w);
    u_spw_host_model.put_word(w);
    #1;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_init();
    put(24'h840005);
    chk({31'h0, calStart}, 32'h0);
    // Fields settle one cycle after the stored word
    @(posedge ref_clk);
    #1;
    chk({31'h0, fields.softReset}, 32'h1);
    put(24'h01048c);
    put(24'h000ba9);
    rdchk(8'h70, 32'h0001048c);
    rdchk(8'h64, 32'h00000ba9);
    u_spw_host_model.settle();
  endtask

  task automatic t_frac();
    put(24'h000003);
    put(24'h351551);
    chk({31'h0, calStart}, 32'h0);
    put(24'h37abc0);
    chk({31'h0, calStart}, 32'h1);
    @(posedge ref_clk);
    #1;
    chk({31'h0, calStart}, 32'h0);
    chk({31'h0, calBusy}, 32'h1);
    chk({21'h0, fields.nDiv}, 32'h00000437);
    chk({10'h0, fields.numerator}, 32'h00000abc);
    chk({28'h0, fields.pumpCurrent}, 32'h0000000a);
    put(24'h400003);
    @(posedge ref_clk);
    #1;
    chk({10'h0, fields.numerator}, 32'h00155abc);
    rdchk(spw_pkg::NUM_OFS, 32'h00155abc);
    rdchk(spw_pkg::NDIV_OFS, 32'h00000437);
  endtask

  task automatic t_cal();
    repeat (spw_pkg::CAL_CYCLES) @(posedge ref_clk);
    #1;
    chk({31'h0, calBusy}, 32'h0);
    rdchk(spw_pkg::STAT_OFS, 32'h00000100);
  endtask

  task automatic t_bad();
    put(24'h12345a);
    chk({31'h0, calStart}, 32'h0);
    rdchk(spw_pkg::STAT_OFS, 32'h00000102);
    rdchk(spw_pkg::PROG_OFS, 32'h0012345a);
    wr(spw_pkg::CTRL_OFS, 32'h00000002);
    rdchk(spw_pkg::STAT_OFS, 32'h00000100);
    rdchk(8'h80, 32'h00000000);
  endtask

  task automatic t_fb();
    wr(spw_pkg::CTRL_OFS, 32'h00000001);
    vcoTick <= 1'b1;
    n = 0;
    while (fbPulse !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (fbPulse !== 1'b1 && n < 3000);
    chk(32'(n), 32'h00000437);
    vcoTick <= 1'b0;
    wr(spw_pkg::CTRL_OFS, 32'h00000000);
  endtask

  // ------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    fails    = 0;
    n_checks = 0;
    arst_n   = 1'b0;
    vcoTick  = 1'b0;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk({31'h0, hreadyout}, 32'h1);
    chk({31'h0, fields === '0}, 32'h1);
    chk({31'h0, hresp}, 32'h0);
    t_init();
    t_frac();
    t_cal();
    t_bad();
    t_fb();
    conclude();
  end

  // Cuts a hung handshake short
  initial begin
    #(40 * 20000);
    fails++;
    conclude();
  end
endmodule // tb_top
`default_nettype wire
